// ### inc/pui_cfg.svh
// Purpose: constants of the packed interleave unit
// Assumes: included by the package and the design modules
// Notes: offsets are byte addresses on the register bus
`ifndef PUI_CFG_SVH
`define PUI_CFG_SVH
`define PUI_OPC_ESC 8'h0F
`define PUI_OPC_HBW 8'h68
`define PUI_OPC_HWD 8'h69
`define PUI_OPC_HDQ 8'h6A
`define PUI_OPC_LBW 8'h60
`define PUI_OPC_LWD 8'h61
`define PUI_OPC_LDQ 8'h62
`define PUI_GRAN_B 2'h0
`define PUI_GRAN_W 2'h1
`define PUI_GRAN_D 2'h2
`define PUI_VEC_UD 5'h06
`define PUI_VEC_NM 5'h07
`define PUI_VEC_MF 5'h10
`define PUI_VEC_GP 5'h0D
`define PUI_VEC_SS 5'h0C
`define PUI_VEC_PF 5'h0E
`define PUI_VEC_AC 5'h11
`define PUI_REAL_LIMIT 33'h00000FFFF
`define PUI_LAST64 33'h000000007
`define PUI_LAST32 33'h000000003
`define PUI_CPL_USER 2'h3
`define PUI_AW 8
`define PUI_OFF_CTRL 8'h00
`define PUI_OFF_STATUS 8'h04
`define PUI_OFF_FAULT 8'h08
`define PUI_OFF_PREG_LO 8'h40
`define PUI_OFF_PREG_HI 8'h7C
`define PUI_CTRL_RESET 7'h00
`define PUI_RESP_OKAY 2'h0
`define PUI_RESP_SLVERR 2'h2
`define PUI_NREGS 8
`endif

// ### inc/pui_pkg.sv
// Purpose: types of the packed interleave unit
// Assumes: constants come from pui_cfg.svh
// Notes: none
`include "pui_cfg.svh"
package pui_pkg;
  typedef enum logic [2:0] {
    PUI_ST_IDLE = 3'b001,
    PUI_ST_LOAD = 3'b010,
    PUI_ST_EXEC = 3'b100
  } pui_state_e;

  typedef enum logic [1:0] {
    PUI_MODE_REAL = 2'b00,
    PUI_MODE_PROT = 2'b01,
    PUI_MODE_V86 = 2'b10,
    PUI_MODE_RSVD = 2'b11
  } pui_mode_e;

  typedef struct packed {
    logic [1:0] cpl;
    pui_mode_e mode;
    logic fpe_pending;
    logic task_switched_bit;
    logic emulation_control_bit;
  } pui_ctrl_s;

  typedef struct packed {
    logic [7:0] esc;
    logic [7:0] opcode;
    logic [2:0] dst;
    logic [2:0] src;
    logic src_mem;
    logic [31:0] ea;
    logic seg_stack;
    logic ea_legal;
  } pui_op_s;

  typedef struct packed {
    logic valid;
    logic [4:0] vec;
    logic has_err;
  } pui_fault_s;

  typedef struct packed {
    logic [31:0] addr;
    logic wide;
  } pui_mem_req_s;

  typedef struct packed {
    logic ack;
    logic pf;
    logic [63:0] data;
  } pui_mem_rsp_s;

  typedef struct packed {
    pui_state_e st;
    logic op_ready;
    pui_op_s op;
    logic [63:0] dval;
    logic [63:0] sval;
    pui_ctrl_s ctrl;
    logic [`PUI_NREGS-1:0][63:0] pregs;
    logic mem_req;
    pui_mem_req_s mem;
    logic wb_valid;
    logic [2:0] wb_idx;
    logic [63:0] wb_data;
    pui_fault_s fault;
    pui_fault_s last_fault;
    logic [15:0] done_cnt;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [`PUI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pui_state_s;
endpackage : pui_pkg

// ### logic/pui_interleave.sv
// Purpose: interleave datapath
// Assumes: memory low operands arrive in bits 31..0 of src
// Notes: purely combinational
`timescale 1ns/100ps
`include "pui_cfg.svh"
module pui_interleave (
  input wire logic high,
  input wire logic [1:0] gran,
  input wire logic [63:0] dst,
  input wire logic [63:0] src,
  output logic [63:0] result
);
  function automatic logic [63:0] mix(logic [1:0] g, logic [31:0] d, logic [31:0] s);
    case (g)
      `PUI_GRAN_B: mix = {s[31:24], d[31:24], s[23:16], d[23:16],
                          s[15:8], d[15:8], s[7:0], d[7:0]};
      `PUI_GRAN_W: mix = {s[31:16], d[31:16], s[15:0], d[15:0]};
      default: mix = {s, d};
    endcase
  endfunction : mix

  always_comb begin
    if (high) begin
      result = mix(gran, dst[63:32], src[63:32]);
    end else begin
      result = mix(gran, dst[31:0], src[31:0]);
    end
  end
endmodule : pui_interleave

// ### logic/pui_fault_check.sv
// Purpose: fault checks taken when an operation is accepted
// Assumes: segment legality is judged by the decoder
// Notes: page faults come later from the load path
`timescale 1ns/100ps
`include "pui_cfg.svh"
module pui_fault_check (
  input wire pui_pkg::pui_ctrl_s ctrl,
  input wire pui_pkg::pui_op_s op,
  input wire logic known,
  input wire logic wide,
  output pui_pkg::pui_fault_s fault
);
  logic [32:0] end_addr;
  logic unaligned;

  always_comb begin
    fault = '0;
    end_addr = {1'b0, op.ea} + (wide ? `PUI_LAST64 : `PUI_LAST32);
    unaligned = wide ? (|op.ea[2:0]) : (|op.ea[1:0]);
    if (!known || ctrl.emulation_control_bit) begin
      fault = '{valid: 1'b1, vec: `PUI_VEC_UD, has_err: 1'b0};
    end else if (ctrl.task_switched_bit) begin
      fault = '{valid: 1'b1, vec: `PUI_VEC_NM, has_err: 1'b0};
    end else if (ctrl.fpe_pending) begin
      fault = '{valid: 1'b1, vec: `PUI_VEC_MF, has_err: 1'b0};
    end else if (op.src_mem) begin
      if (ctrl.mode == pui_pkg::PUI_MODE_PROT) begin
        if (!op.ea_legal) begin
          fault = '{valid: 1'b1, vec: op.seg_stack ? `PUI_VEC_SS : `PUI_VEC_GP,
                    has_err: 1'b1};
        end else if (unaligned && ctrl.cpl == `PUI_CPL_USER) begin
          fault = '{valid: 1'b1, vec: `PUI_VEC_AC, has_err: 1'b1};
        end
      end else begin
        if (end_addr > `PUI_REAL_LIMIT) begin
          fault = '{valid: 1'b1, vec: `PUI_VEC_GP, has_err: 1'b0};
        end else if (ctrl.mode == pui_pkg::PUI_MODE_V86 && unaligned) begin
          fault = '{valid: 1'b1, vec: `PUI_VEC_AC, has_err: 1'b1};
        end
      end
    end
  end
endmodule : pui_fault_check

// ### logic/pui_top.sv
// Purpose: packed interleave unit with its packed register file
// Assumes: AXI4-Lite register access, decoder and load path on aclk
// Notes: one operation in flight; faults report instead of writing back
`timescale 1ns/100ps
`include "pui_cfg.svh"
module pui_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PUI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PUI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_valid,
  input wire pui_pkg::pui_op_s op_in,
  output logic op_ready,
  output logic mem_req,
  output pui_pkg::pui_mem_req_s mem_out,
  input wire pui_pkg::pui_mem_rsp_s mem_rsp,
  output logic wb_valid,
  output logic [2:0] wb_idx,
  output logic [63:0] wb_data,
  output pui_pkg::pui_fault_s fault_out
);
  pui_pkg::pui_state_s q;
  pui_pkg::pui_state_s d;
  pui_pkg::pui_fault_s chk_fault;
  logic [63:0] ilv_result;
  logic [3:0] in_dec;
  logic [3:0] q_dec;
  logic accept;

  // returns {known, high, granularity}
  function automatic logic [3:0] decode(logic [7:0] esc, logic [7:0] opc);
    decode = 4'h0;
    if (esc == `PUI_OPC_ESC) begin
      case (opc)
        `PUI_OPC_HBW: decode = {2'b11, `PUI_GRAN_B};
        `PUI_OPC_HWD: decode = {2'b11, `PUI_GRAN_W};
        `PUI_OPC_HDQ: decode = {2'b11, `PUI_GRAN_D};
        `PUI_OPC_LBW: decode = {2'b10, `PUI_GRAN_B};
        `PUI_OPC_LWD: decode = {2'b10, `PUI_GRAN_W};
        `PUI_OPC_LDQ: decode = {2'b10, `PUI_GRAN_D};
        default: decode = 4'h0;
      endcase
    end
  endfunction : decode

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  assign in_dec = decode(op_in.esc, op_in.opcode);
  assign q_dec = decode(q.op.esc, q.op.opcode);
  assign accept = op_valid && q.op_ready;

  pui_fault_check u_fault (
    .ctrl(q.ctrl),
    .op(op_in),
    .known(in_dec[3]),
    .wide(in_dec[2]),
    .fault(chk_fault)
  );

  pui_interleave u_ilv (
    .high(q_dec[2]),
    .gran(q_dec[1:0]),
    .dst(q.dval),
    .src(q.sval),
    .result(ilv_result)
  );

  always_comb begin
    d = q;
    d.wb_valid = 1'b0;
    d.fault = '0;
    // register bus write side
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (d.aw_got && d.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `PUI_RESP_OKAY;
      if (d.awaddr[7:2] == `PUI_OFF_CTRL >> 2) begin
        d.ctrl = pui_pkg::pui_ctrl_s'(7'(merge({25'h0, q.ctrl}, d.wdata, d.wstrb)));
      end else if (d.awaddr >= `PUI_OFF_PREG_LO && d.awaddr <= `PUI_OFF_PREG_HI) begin
        d.pregs[d.awaddr[5:3]][32*d.awaddr[2] +: 32] =
          merge(q.pregs[d.awaddr[5:3]][32*d.awaddr[2] +: 32], d.wdata, d.wstrb);
      end else if (d.awaddr[7:2] == `PUI_OFF_STATUS >> 2 ||
                   d.awaddr[7:2] == `PUI_OFF_FAULT >> 2) begin
        d.bresp = `PUI_RESP_OKAY;
      end else begin
        d.bresp = `PUI_RESP_SLVERR;
      end
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    // register bus read side
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = `PUI_RESP_OKAY;
      d.rdata = 32'h0;
      if (s_axi_araddr[7:2] == `PUI_OFF_CTRL >> 2) begin
        d.rdata = {25'h0, q.ctrl};
      end else if (s_axi_araddr[7:2] == `PUI_OFF_STATUS >> 2) begin
        d.rdata = {q.done_cnt, 13'h0, q.st};
      end else if (s_axi_araddr[7:2] == `PUI_OFF_FAULT >> 2) begin
        d.rdata = {q.last_fault.valid, 22'h0, q.last_fault.has_err, 3'h0,
                   q.last_fault.vec};
      end else if (s_axi_araddr >= `PUI_OFF_PREG_LO &&
                   s_axi_araddr <= `PUI_OFF_PREG_HI) begin
        d.rdata = q.pregs[s_axi_araddr[5:3]][32*s_axi_araddr[2] +: 32];
      end else begin
        d.rresp = `PUI_RESP_SLVERR;
      end
    end
    d.arready = !d.rvalid;
    // operation sequencer
    case (q.st)
      pui_pkg::PUI_ST_IDLE: begin
        if (accept) begin
          d.op = op_in;
          d.dval = q.pregs[op_in.dst];
          d.sval = q.pregs[op_in.src];
          if (chk_fault.valid) begin
            d.fault = chk_fault;
            d.last_fault = chk_fault;
          end else if (op_in.src_mem) begin
            d.mem_req = 1'b1;
            d.mem.addr = op_in.ea;
            d.mem.wide = in_dec[2];
            d.st = pui_pkg::PUI_ST_LOAD;
          end else begin
            d.st = pui_pkg::PUI_ST_EXEC;
          end
        end
      end
      pui_pkg::PUI_ST_LOAD: begin
        if (mem_rsp.ack) begin
          d.mem_req = 1'b0;
          if (mem_rsp.pf) begin
            d.fault = '{valid: 1'b1, vec: `PUI_VEC_PF, has_err: 1'b1};
            d.last_fault = d.fault;
            d.st = pui_pkg::PUI_ST_IDLE;
          end else begin
            d.sval = q.mem.wide ? mem_rsp.data : {32'h0, mem_rsp.data[31:0]};
            d.st = pui_pkg::PUI_ST_EXEC;
          end
        end
      end
      pui_pkg::PUI_ST_EXEC: begin
        d.pregs[q.op.dst] = ilv_result;
        d.wb_valid = 1'b1;
        d.wb_idx = q.op.dst;
        d.wb_data = ilv_result;
        d.done_cnt = q.done_cnt + 16'h0001;
        d.st = pui_pkg::PUI_ST_IDLE;
      end
      default: begin
        d.st = pui_pkg::PUI_ST_IDLE;
      end
    endcase
    d.op_ready = (d.st == pui_pkg::PUI_ST_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= pui_pkg::PUI_ST_IDLE;
      q.ctrl <= pui_pkg::pui_ctrl_s'(`PUI_CTRL_RESET);
      q.op_ready <= 1'b1;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign op_ready = q.op_ready;
  assign mem_req = q.mem_req;
  assign mem_out = q.mem;
  assign wb_valid = q.wb_valid;
  assign wb_idx = q.wb_idx;
  assign wb_data = q.wb_data;
  assign fault_out = q.fault;

  property p_em_ud;
    @(posedge aclk) disable iff (!aresetn)
    accept && q.ctrl.emulation_control_bit |=> q.fault.valid && q.fault.vec == `PUI_VEC_UD;
  endproperty
  a_em_ud: assert property (p_em_ud) else $error("emulation bit did not fault");

  property p_ts_nm;
    @(posedge aclk) disable iff (!aresetn)
    accept && in_dec[3] && !q.ctrl.emulation_control_bit && q.ctrl.task_switched_bit
      |=> q.fault.valid && q.fault.vec == `PUI_VEC_NM;
  endproperty
  a_ts_nm: assert property (p_ts_nm) else $error("task switched did not fault");

  property p_fpe_mf;
    @(posedge aclk) disable iff (!aresetn)
    accept && in_dec[3] && q.ctrl == pui_pkg::pui_ctrl_s'({q.ctrl[6:3], 3'b100})
      |=> q.fault.vec == `PUI_VEC_MF ##1 !q.wb_valid;
  endproperty
  a_fpe_mf: assert property (p_fpe_mf) else $error("pending exception did not fault");

  property p_fault_no_wb;
    @(posedge aclk) disable iff (!aresetn)
    accept && chk_fault.valid |=> !q.wb_valid && q.op_ready ##1 !q.wb_valid;
  endproperty
  a_fault_no_wb: assert property (p_fault_no_wb) else $error("faulting op wrote back");

  property p_mem_width;
    @(posedge aclk) disable iff (!aresetn)
    q.mem_req |-> q.mem.wide == q_dec[2];
  endproperty
  a_mem_width: assert property (p_mem_width) else $error("wrong load width");

  property p_req_hold;
    @(posedge aclk) disable iff (!aresetn)
    q.mem_req && !mem_rsp.ack |=> q.mem_req && $stable(q.mem.addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("load request dropped");

  property p_hbw;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_EXEC && q.op.opcode == `PUI_OPC_HBW
      |=> q.wb_valid && q.wb_data[63:56] == $past(q.sval[63:56])
          && q.wb_data[7:0] == $past(q.dval[39:32]);
  endproperty
  a_hbw: assert property (p_hbw) else $error("high byte interleave wrong");

  property p_ldq;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_EXEC && q.op.opcode == `PUI_OPC_LDQ
      |=> q.wb_data == {$past(q.sval[31:0]), $past(q.dval[31:0])};
  endproperty
  a_ldq: assert property (p_ldq) else $error("low dword interleave wrong");

  property p_ac_user;
    @(posedge aclk) disable iff (!aresetn)
    q.fault.valid && q.fault.vec == `PUI_VEC_AC && $past(q.ctrl.mode) == pui_pkg::PUI_MODE_PROT
      |-> $past(q.ctrl.cpl) == `PUI_CPL_USER;
  endproperty
  a_ac_user: assert property (p_ac_user) else $error("alignment fault below level 3");

  property p_hwd;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_EXEC && q.op.opcode == `PUI_OPC_HWD
      |=> q.wb_data == {$past(q.sval[63:48]), $past(q.dval[63:48]),
                        $past(q.sval[47:32]), $past(q.dval[47:32])};
  endproperty
  a_hwd: assert property (p_hwd) else $error("high word interleave wrong");

  property p_hdq;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_EXEC && q.op.opcode == `PUI_OPC_HDQ
      |=> q.wb_data == {$past(q.sval[63:32]), $past(q.dval[63:32])};
  endproperty
  a_hdq: assert property (p_hdq) else $error("high dword interleave wrong");

  property p_lbw;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_EXEC && q.op.opcode == `PUI_OPC_LBW
      |=> q.wb_data[63:56] == $past(q.sval[31:24]) && q.wb_data[7:0] == $past(q.dval[7:0]);
  endproperty
  a_lbw: assert property (p_lbw) else $error("low byte interleave wrong");

  property p_lwd;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_EXEC && q.op.opcode == `PUI_OPC_LWD
      |=> q.wb_data == {$past(q.sval[31:16]), $past(q.dval[31:16]),
                        $past(q.sval[15:0]), $past(q.dval[15:0])};
  endproperty
  a_lwd: assert property (p_lwd) else $error("low word interleave wrong");

  property p_exec_wb;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_EXEC
      |=> q.wb_valid && q.wb_idx == $past(q.op.dst) && q.pregs[q.wb_idx] == q.wb_data;
  endproperty
  a_exec_wb: assert property (p_exec_wb) else $error("result not written to destination");

  property p_lo_load;
    @(posedge aclk) disable iff (!aresetn)
    q.st == pui_pkg::PUI_ST_LOAD && mem_rsp.ack && !mem_rsp.pf && !q.mem.wide
      |=> q.sval[31:0] == $past(mem_rsp.data[31:0]);
  endproperty
  a_lo_load: assert property (p_lo_load) else $error("short load not used whole");

  property p_gp_real;
    @(posedge aclk) disable iff (!aresetn)
    q.fault.valid && q.fault.vec == `PUI_VEC_GP && $past(q.ctrl.mode) != pui_pkg::PUI_MODE_PROT
      |-> !q.fault.has_err;
  endproperty
  a_gp_real: assert property (p_gp_real) else $error("limit fault carried error code");
endmodule : pui_top

// ### tb/pui_load_model.sv
// Purpose: memory load path seen by the interleave unit
// Assumes: one request at a time, held until ack
// Notes: unused data bits carry a changing pattern
`timescale 1ns/100ps
module pui_load_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_req,
  input wire pui_pkg::pui_mem_req_s mem_out,
  input wire logic [3:0] delay,
  input wire logic [31:0] pf_addr,
  output pui_pkg::pui_mem_rsp_s mem_rsp
);
  typedef struct packed {
    logic [3:0] cnt;
    logic ack;
    logic [63:0] junk;
  } pui_ld_s;
  pui_ld_s st_q;
  pui_ld_s st_d;
  always_comb begin
    st_d = st_q;
    st_d.junk = {st_q.junk[62:0], ~st_q.junk[63]};
    st_d.ack = 1'b0;
    if (!mem_req || st_q.ack) begin
      st_d.cnt = 4'h0;
    end else if (st_q.cnt == delay) begin
      st_d.ack = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= {4'h0, 1'b0, 64'h0123_4567_89AB_CDEF};
    end else begin
      st_q <= st_d;
    end
  end
  always_comb begin
    mem_rsp.ack = st_q.ack;
    mem_rsp.pf = st_q.ack && (mem_out.addr == pf_addr);
    mem_rsp.data = st_q.junk;
    if (st_q.ack) begin
      mem_rsp.data[31:0] = mem_out.addr ^ 32'h5A5A_5A5A;
      if (mem_out.wide) begin
        mem_rsp.data[63:32] = ~mem_out.addr;
      end
    end
  end
endmodule : pui_load_model

// ### tb/packed_unpack_interleave_unit_tb.sv
// Purpose: self-checking bench of the packed interleave unit
// Assumes: load path model answers memory requests
// Notes: data and addresses from an lfsr
`timescale 1ns/100ps
`include "pui_cfg.svh"
module packed_unpack_interleave_unit_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, pf_addr, seed, rd;
  logic [3:0] s_axi_wstrb, dly;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic op_valid, op_ready, mem_req, wb_valid;
  logic [2:0] wb_idx;
  logic [63:0] wb_data;
  pui_pkg::pui_op_s op_in;
  pui_pkg::pui_mem_req_s mem_out;
  pui_pkg::pui_mem_rsp_s mem_rsp;
  pui_pkg::pui_fault_s fault_out;
  logic [63:0] regs [8];
  logic [7:0] opc [6] = '{`PUI_OPC_HBW, `PUI_OPC_HWD, `PUI_OPC_HDQ, `PUI_OPC_LBW,
    `PUI_OPC_LWD, `PUI_OPC_LDQ};
  logic [31:0] ctl [4] = '{32'h1, 32'h2, 32'h4, 32'h3};
  logic [4:0] fv [4] = '{`PUI_VEC_UD, `PUI_VEC_NM, `PUI_VEC_MF, `PUI_VEC_UD};
  int fail_count, checked;
  pui_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .op_valid, .op_in, .op_ready, .mem_req, .mem_out, .mem_rsp, .wb_valid,
    .wb_idx, .wb_data, .fault_out);
  pui_load_model ld (.aclk, .aresetn, .mem_req, .mem_out, .delay(dly), .pf_addr, .mem_rsp);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // reference interleave: pairs of dest then source elements from one half
  function automatic logic [63:0] ilv(input logic hi, input logic [1:0] g,
    input logic [63:0] d, input logic [63:0] s);
    logic [63:0] r;
    int w;
    int b;
    w = 8 << g;
    for (int i = 0; i < 64; i++) begin
      b = (hi ? 32 : 0) + (i / (2 * w)) * w + i % (2 * w);
      r[i] = (i % (2 * w) < w) ? d[b] : s[b - w];
    end
    return r;
  endfunction : ilv
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n >= 40) begin
      fail_count++;
      report_and_stop();
    end
  endtask : tmo
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk(s_axi_bresp, er);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    tmo(n);
    chk(s_axi_rresp, er);
  endtask : axr
  task automatic do_op(input logic [7:0] esc, input logic [7:0] op, input logic [2:0] dd,
    input logic [2:0] ss, input logic mem, input logic [31:0] ea, input logic stk,
    input logic lg, input logic [4:0] xv);
    logic [63:0] e;
    logic gotm;
    int n;
    e = ilv(op[3], op[1:0], regs[dd], mem ? {~ea, ea ^ 32'h5A5A_5A5A} : regs[ss]);
    gotm = 1'b0;
    @(posedge aclk);
    op_in <= '{esc, op, dd, ss, mem, ea, stk, lg};
    op_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (op_ready !== 1'b1 && n < 40);
    op_valid <= 1'b0;
    tmo(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (mem_req === 1'b1 && !gotm) begin
        gotm = 1'b1;
        chk(mem_out, {ea, op[3]});
      end
    end while (wb_valid !== 1'b1 && fault_out.valid !== 1'b1 && n < 40);
    tmo(n);
    if (xv == 5'h1F) begin
      chk({wb_valid, fault_out.valid, gotm}, {2'b10, mem});
      chk(wb_idx, dd);
      chk(wb_data, e);
      regs[dd] = e;
    end else begin
      chk({wb_valid, fault_out.valid, fault_out.vec}, {2'b01, xv});
    end
  endtask : do_op
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, op_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, op_in, dly} = '0;
    s_axi_wstrb = 4'hF;
    pf_addr = 32'hFFFF_FFFF;
    seed = 32'hFE33_66C5;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`PUI_OFF_CTRL, `PUI_RESP_OKAY);
    chk(rd, 32'h0);
    axr(`PUI_OFF_STATUS, `PUI_RESP_OKAY);
    chk(rd[2:0], 3'h1);
    axr(8'h10, `PUI_RESP_SLVERR);
    axw(8'h10, 32'h1, `PUI_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      regs[i] = {rnd(), rnd()};
      axw(8'(8'h40 + 8 * i), regs[i][31:0], `PUI_RESP_OKAY);
      axw(8'(8'h44 + 8 * i), regs[i][63:32], `PUI_RESP_OKAY);
    end
    axr(8'h4C, `PUI_RESP_OKAY);
    chk(rd, regs[1][63:32]);
    for (int k = 0; k < 12; k++) begin
      rd = rnd();
      do_op(8'h0F, opc[k % 6], rd[2:0], (k < 6) ? rd[5:3] : rd[2:0], 1'b0, 32'h0, 1'b0, 1'b1,
        5'h1F);
    end
    for (int k = 0; k < 6; k++) begin
      rd = rnd();
      dly <= rd[19:16];
      do_op(8'h0F, opc[k], rd[2:0], 3'h0, 1'b1, {17'h0, rd[14:3], 3'h0}, 1'b0, 1'b1,
        5'h1F);
    end
    do_op(8'h0F, opc[0], 3'h2, 3'h0, 1'b1, 32'hFFFC, 1'b0, 1'b1, `PUI_VEC_GP);
    do_op(8'h0F, opc[3], 3'h2, 3'h0, 1'b1, 32'hFFFC, 1'b0, 1'b1, 5'h1F);
    for (int k = 0; k < 4; k++) begin
      axw(`PUI_OFF_CTRL, ctl[k], `PUI_RESP_OKAY);
      do_op(8'h0F, opc[k], 3'h3, 3'h4, 1'b0, 32'h0, 1'b0, 1'b1, fv[k]);
    end
    axw(`PUI_OFF_CTRL, 32'h08, `PUI_RESP_OKAY);
    do_op(8'h0F, 8'h63, 3'h3, 3'h4, 1'b0, 32'h0, 1'b0, 1'b1, `PUI_VEC_UD);
    do_op(8'h0E, opc[0], 3'h3, 3'h4, 1'b0, 32'h0, 1'b0, 1'b1, `PUI_VEC_UD);
    do_op(8'h0F, opc[1], 3'h5, 3'h0, 1'b1, 32'h100, 1'b0, 1'b0, `PUI_VEC_GP);
    do_op(8'h0F, opc[1], 3'h5, 3'h0, 1'b1, 32'h100, 1'b1, 1'b0, `PUI_VEC_SS);
    pf_addr <= 32'h200;
    do_op(8'h0F, opc[4], 3'h5, 3'h0, 1'b1, 32'h200, 1'b0, 1'b1, `PUI_VEC_PF);
    do_op(8'h0F, opc[4], 3'h6, 3'h0, 1'b1, 32'h201, 1'b0, 1'b1, 5'h1F);
    axw(`PUI_OFF_CTRL, 32'h68, `PUI_RESP_OKAY);
    do_op(8'h0F, opc[5], 3'h5, 3'h0, 1'b1, 32'h201, 1'b0, 1'b1, `PUI_VEC_AC);
    axw(`PUI_OFF_CTRL, 32'h10, `PUI_RESP_OKAY);
    do_op(8'h0F, opc[5], 3'h5, 3'h0, 1'b1, 32'h203, 1'b0, 1'b1, `PUI_VEC_AC);
    do_op(8'h0F, opc[2], 3'h5, 3'h0, 1'b1, 32'h200, 1'b0, 1'b1, `PUI_VEC_PF);
    do_op(8'h0F, opc[2], 3'h5, 3'h0, 1'b1, 32'h1_0000, 1'b0, 1'b1, `PUI_VEC_GP);
    axr(`PUI_OFF_FAULT, `PUI_RESP_OKAY);
    chk({rd[31], rd[4:0]}, {1'b1, `PUI_VEC_GP});
    axr(8'h68, `PUI_RESP_OKAY);
    chk(rd, regs[5][31:0]);
    axr(8'h6C, `PUI_RESP_OKAY);
    chk(rd, regs[5][63:32]);
    report_and_stop();
  end
endmodule : packed_unpack_interleave_unit_tb
